// *** verilog/supervisor_watchdog_reset.sv ***
// Reset supervisor: supply monitor, debounced manual request, watchdog.
// Assumes supply_good and kick_floating come from analog/pin logic on other domains.
// What this block does
// - Every reset drives reset_out_n low for the 200 ms hold period before release.
// - reset_out_n stays low while supply is bad or the manual request is held low.
// - Supply rising, watchdog expiry or manual request release starts the hold period.
// - reset_out is always the inverse of reset_out_n.
// - A kick input held at one level past 1.6 s expires the watchdog and resets.
// - The watchdog timer clears on reset and on every rising or falling kick edge.
// - Kick pulses down to 50 ns are seen as valid toggles.
// - The watchdog is held at zero during reset and counts once reset releases.
// - A floating kick input is driven low for 7/8 of the timeout, then high for two clocks as its own edge clears the watchdog.
// - With the kick input floating the internal drive services the watchdog before timeout.
// - Each supply drop restarts the hold timer so every reset lasts the full period.
// - A bouncing switch on the manual request gives one clean reset per press.
module supervisor_watchdog_reset
    import supervisor_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic supply_good,
    input  wire logic manual_request_n,
    input  wire logic kick_input,
    input  wire logic kick_floating,
    output logic      kick_drive,
    output logic      kick_drive_oe,
    output logic      reset_out_n,
    output logic      reset_out
);
    import supervisor_pkg::*;

    logic                tick;
    logic [1:0]          sup_sync_q;
    logic [1:0]          mr_sync_q;
    logic [1:0]          kick_sync_q;
    logic [1:0]          float_sync_q;
    logic                kick_last_q;
    logic                mr_clean_q;
    logic [4:0]          mr_deb_q;
    logic [CNT_W-1:0]    hold_q;
    logic [CNT_W-1:0]    wdog_q;
    logic                kick_drive_q;
    logic                rst_q;
    sup_state_type       state_q;
    sup_state_type       state_d;

    // Shared millisecond enable for the debounce, hold and watchdog timers
    tick_divider #(
        .TICK_CYCLES_P (TICK_CYCLES_P)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // Two-stage synchronisers; 40 ns sampling catches any 50 ns pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sup_sync_q   <= 2'h0;
            mr_sync_q    <= 2'h3;
            kick_sync_q  <= 2'h0;
            float_sync_q <= 2'h0;
        end else begin
            sup_sync_q   <= {sup_sync_q[0], supply_good};
            mr_sync_q    <= {mr_sync_q[0], manual_request_n};
            kick_sync_q  <= {kick_sync_q[0], kick_input};
            float_sync_q <= {float_sync_q[0], kick_floating};
        end
    end

    wire sup_ok   = sup_sync_q[1];
    wire floating = float_sync_q[1];
    // When floating, the kick seen is our own drive
    wire kick_lvl = floating ? kick_drive_q : kick_sync_q[1];
    wire kick_edge = (kick_lvl != kick_last_q);

    // Manual request debounce: level must hold steady for DEBOUNCE_MS
    wire mr_raw    = mr_sync_q[1];
    wire mr_differ = (mr_raw != mr_clean_q);
    wire mr_settle = mr_differ && tick && (mr_deb_q == 5'(DEBOUNCE_MS - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mr_deb_q   <= 5'h00;
            mr_clean_q <= 1'b1;
        end else begin
            if (!mr_differ) begin
                mr_deb_q <= 5'h00;
            end else if (tick) begin
                mr_deb_q <= mr_settle ? 5'h00 : mr_deb_q + 5'h01;
            end
            if (mr_settle) begin
                mr_clean_q <= mr_raw;
            end
        end
    end

    // Reset is held while a cause is present
    wire cause     = !sup_ok || !mr_clean_q;
    wire hold_done = tick && (hold_q == CNT_W'(HOLD_PERIOD_MS - 1));
    wire wd_expire = tick && (wdog_q == CNT_W'(TIMEOUT_MS - 1));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_ASSERT: if (!cause) state_d = ST_HOLD;
            ST_HOLD: begin
                if (cause) begin
                    state_d = ST_ASSERT;
                end else if (hold_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cause) begin
                    state_d = ST_ASSERT;
                end else if (wd_expire) begin
                    state_d = ST_HOLD;
                end
            end
            default: state_d = ST_ASSERT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_ASSERT;
        end else begin
            state_q <= state_d;
        end
    end

    // Hold timer restarts whenever the block leaves the hold state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (state_q != ST_HOLD || state_d != ST_HOLD) begin
            hold_q <= '0;
        end else if (tick) begin
            hold_q <= hold_q + 1'b1;
        end
    end

    // Watchdog timer: cleared in reset and on every kick edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdog_q      <= '0;
            kick_last_q <= 1'b0;
        end else begin
            kick_last_q <= kick_lvl;
            if (state_q != ST_RUN || kick_edge || wd_expire) begin
                wdog_q <= '0;
            end else if (tick) begin
                wdog_q <= wdog_q + 1'b1;
            end
        end
    end

    // Internal drive: high once the count reaches 7/8 of the timeout, so a floating
    // input toggles at 1.4 s and services the counter before 1.6 s
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kick_drive_q <= 1'b0;
        end else begin
            kick_drive_q <= (wdog_q >= CNT_W'(KICK_HIGH_MS));
        end
    end

    assign kick_drive    = kick_drive_q;
    assign kick_drive_oe = floating;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= (state_d != ST_RUN);
        end
    end

    assign reset_out_n = rst_q ? RESET_LVL_N : !RESET_LVL_N;
    assign reset_out   = !reset_out_n;

    // Assertions
    chk_inverse_out: assert property (@(posedge clk) disable iff (!rst_n)
        reset_out == !reset_out_n)
        else $error("complement output not inverse");

    chk_cause_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (cause && state_q != ST_RUN) |=> !reset_out_n)
        else $error("reset released while cause present");

    chk_hold_full: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_HOLD && state_d == ST_RUN) |-> hold_q == CNT_W'(HOLD_PERIOD_MS - 1))
        else $error("hold period not full");

    chk_wdog_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q != ST_RUN) |=> wdog_q == '0)
        else $error("watchdog counted during reset");

    chk_kick_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (kick_edge && state_q == ST_RUN) |=> wdog_q == '0)
        else $error("kick edge did not clear watchdog");

    chk_wdog_fire: assert property (@(posedge clk) disable iff (!rst_n)
        (wd_expire && state_q == ST_RUN && !cause) |=> state_q == ST_HOLD ##1 !reset_out_n)
        else $error("watchdog expiry did not reset");

    chk_drive_frac: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(kick_drive_q) |-> $past(wdog_q) >= CNT_W'(KICK_HIGH_MS))
        else $error("internal drive high too early");

    chk_supply_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_HOLD && cause) |=> state_q == ST_ASSERT ##1 hold_q == '0)
        else $error("hold timer not restarted");

    chk_mr_stable: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(mr_clean_q) |-> $past(mr_raw) == mr_clean_q)
        else $error("manual request changed without settle");

    // Ticks spent with reset asserted, saturating; checks the full hold
    logic [CNT_W-1:0] low_len_q;
    wire              low_len_max = (low_len_q == '1);

    always_ff @(posedge clk) begin
        if (!rst_n || !rst_q) begin
            low_len_q <= '0;
        end else if (tick && !low_len_max) begin
            low_len_q <= low_len_q + 1'b1;
        end
    end

    // Ticks since the last kick edge while running, saturating
    logic [CNT_W-1:0] quiet_q;
    wire              quiet_max = (quiet_q == '1);

    always_ff @(posedge clk) begin
        if (!rst_n || state_q != ST_RUN || kick_edge) begin
            quiet_q <= '0;
        end else if (tick && !quiet_max) begin
            quiet_q <= quiet_q + 1'b1;
        end
    end

    chk_low_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_out_n) |-> low_len_q >= CNT_W'(HOLD_PERIOD_MS))
        else $error("reset released before full hold");

    chk_quiet_limit: assert property (@(posedge clk) disable iff (!rst_n)
        quiet_q <= CNT_W'(TIMEOUT_MS))
        else $error("kick quiet past the timeout");

    chk_quiet_fire: assert property (@(posedge clk) disable iff (!rst_n)
        (quiet_q == CNT_W'(TIMEOUT_MS)) |-> !reset_out_n)
        else $error("quiet kick did not reset");

    chk_tick_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick)
        else $error("tick longer than one cycle");

    chk_assert_low: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_ASSERT) |-> !reset_out_n)
        else $error("reset high in assert state");

    chk_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_HOLD) |-> !reset_out_n)
        else $error("reset high in hold state");

    chk_run_high: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_RUN) |-> reset_out_n)
        else $error("reset low while running");

    chk_release_path: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_out_n) |-> $past(state_q) == ST_HOLD)
        else $error("reset released without hold");

    chk_wdog_bound: assert property (@(posedge clk) disable iff (!rst_n)
        wdog_q <= CNT_W'(TIMEOUT_MS - 1))
        else $error("watchdog count past timeout");

    chk_hold_bound: assert property (@(posedge clk) disable iff (!rst_n)
        hold_q <= CNT_W'(HOLD_PERIOD_MS - 1))
        else $error("hold count past period");

    chk_drive_low: assert property (@(posedge clk) disable iff (!rst_n)
        (wdog_q < CNT_W'(KICK_HIGH_MS)) |=> !kick_drive_q)
        else $error("internal drive high in early part");

    chk_drive_high: assert property (@(posedge clk) disable iff (!rst_n)
        (wdog_q >= CNT_W'(KICK_HIGH_MS)) |=> kick_drive_q)
        else $error("internal drive low in last part");

    chk_service_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (floating && $rose(kick_drive_q)) |-> $past(wdog_q) == CNT_W'(SERVICE_MS))
        else $error("internal service at wrong count");

    chk_kick_track: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> kick_last_q == $past(kick_lvl))
        else $error("kick level not tracked every cycle");

    chk_mr_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !mr_differ |=> mr_deb_q == 5'h00)
        else $error("debounce count kept while steady");

    chk_mr_cause: assert property (@(posedge clk) disable iff (!rst_n)
        !mr_clean_q |=> !reset_out_n)
        else $error("manual request did not hold reset");

    chk_supply_cause: assert property (@(posedge clk) disable iff (!rst_n)
        !sup_ok |=> !reset_out_n)
        else $error("low supply did not hold reset");

    chk_wdog_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_RUN && !kick_edge && !wd_expire && tick)
        |=> wdog_q == $past(wdog_q) + 1'b1)
        else $error("watchdog did not step on tick");

    chk_hold_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_HOLD && state_d == ST_HOLD && tick)
        |=> hold_q == $past(hold_q) + 1'b1)
        else $error("hold timer did not step on tick");
endmodule

// *** verilog/supervisor_pkg.sv ***
// Shared constants for the reset supervisor.
// Assumes a single 25 MHz clock; all slow timing runs off a 1 ms tick.
package supervisor_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_NS         = 1_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W          = 15;
    localparam int unsigned HOLD_PERIOD_MS  = 200;
    localparam int unsigned TIMEOUT_MS      = 1600;
    localparam int unsigned SERVICE_MS      = 1400;
    localparam int unsigned KICK_HIGH_MS    = TIMEOUT_MS * 7 / 8;
    localparam int unsigned CNT_W           = 11;
    localparam int unsigned KICK_MIN_NS     = 50;
    localparam int unsigned KICK_MIN_CYCLES =
        (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam logic        RESET_LVL_N     = 1'b0;

    typedef enum logic [1:0] {
        ST_ASSERT = 2'b00,
        ST_HOLD   = 2'b01,
        ST_RUN    = 2'b10
    } sup_state_type;
endpackage

// *** verilog/tick_divider.sv ***
// Free-running divider producing a one-cycle enable every millisecond.
// Assumes clk at the package rate and synchronous active-low reset.
module tick_divider
    import supervisor_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [TICK_W-1:0] div_q;
    wire               wrap = (div_q == TICK_W'(TICK_CYCLES_P - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
            tick  <= 1'b0;
        end else begin
            div_q <= wrap ? '0 : div_q + 1'b1;
            tick  <= wrap;
        end
    end
endmodule

// *** testbench/host_model.sv ***
// Host side of the kick pin: short kick pulses, or the pin left floating.
// Assumes the bench clock; the block's kick drive resolves the floating pin.
module host_model (
    input  wire logic clk,
    input  wire logic kick_en,
    input  wire logic float_en,
    input  wire logic kick_drive,
    input  wire logic kick_drive_oe,
    output logic      kick_input,
    output logic      kick_floating
);
    timeunit 1ns;
    timeprecision 1ns;
    // 100 ms between kicks at the bench's 10-cycle millisecond
    localparam int GAP = 1_000;
    int   cnt_q  = 0;
    logic host_q = 1'b0;
    logic last_q = 1'b0;
    always @(posedge clk) begin
        cnt_q  <= (!kick_en || cnt_q == GAP - 1) ? 0 : cnt_q + 1;
        // Set at one count, cleared two cycles later: an 80 ns high pulse
        host_q <= kick_en && (cnt_q < 2);
        last_q <= kick_input;
    end
    // A released pin shows the inverse of its last level
    assign kick_floating = float_en;
    assign kick_input    = !float_en ? host_q : (kick_drive_oe ? kick_drive : !last_q);
endmodule

// *** testbench/supervisor_watchdog_reset_tb.sv ***
// Self-checking bench for the reset supervisor with a host kick model.
// Overrides the package TICK_CYCLES with a tick of SIM_TICK clocks per millisecond.
module supervisor_watchdog_reset_tb;
    import supervisor_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened millisecond so the whole run fits in a short simulation
    localparam int SIM_TICK = 10;
    logic clk              = 1'b0;
    logic rst_n            = 1'b0;
    logic supply_good      = 1'b0;
    logic manual_request_n = 1'b1;
    logic kick_en          = 1'b0;
    logic float_en         = 1'b0;
    logic drive_seen       = 1'b0;
    logic kick_input;
    logic kick_floating;
    logic kick_drive;
    logic kick_drive_oe;
    logic reset_out_n;
    logic reset_out;
    int   num_errors       = 0;
    int   n_tests          = 0;
    int   cycles           = 0;

    always #20 clk = ~clk;

    supervisor_watchdog_reset #(.TICK_CYCLES_P(SIM_TICK)) uut (.clk(clk), .rst_n(rst_n),
        .supply_good(supply_good),
        .manual_request_n(manual_request_n), .kick_input(kick_input),
        .kick_floating(kick_floating), .kick_drive(kick_drive),
        .kick_drive_oe(kick_drive_oe), .reset_out_n(reset_out_n), .reset_out(reset_out));

    host_model host (.clk(clk), .kick_en(kick_en), .float_en(float_en),
        .kick_drive(kick_drive), .kick_drive_oe(kick_drive_oe),
        .kick_input(kick_input), .kick_floating(kick_floating));

    // Whole run is about 6.2 s of device time, near 62,000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (kick_drive_oe === 1'b1 && kick_drive === 1'b1)
            drive_seen <= 1'b1;
        if (cycles == 70_000) begin
            num_errors++;
            results();
        end
    end

    task automatic wait_ms(input int ms);
        repeat (ms * SIM_TICK) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic check(input string what, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic check_rst(input logic exp);
        check("reset_out_n", reset_out_n, exp);
        check("reset_out", reset_out, ~exp);
    endtask

    task automatic set_supply(input logic v, input int ms);
        @(posedge clk) supply_good <= v;
        wait_ms(ms);
    endtask

    task automatic set_mr(input logic v, input int ms);
        @(posedge clk) manual_request_n <= v;
        wait_ms(ms);
    endtask

    task automatic t_power_up;
        wait_ms(5);
        check_rst(1'b0);
        @(posedge clk) kick_en <= 1'b1;
        set_supply(1'b1, 195);
        check_rst(1'b0);
        wait_ms(10);
        check_rst(1'b1);
        $display("power up test done");
    endtask

    task automatic t_brownout;
        set_supply(1'b0, 2);
        check_rst(1'b0);
        set_supply(1'b1, 100);
        set_supply(1'b0, 1);
        set_supply(1'b1, 195);
        check_rst(1'b0);
        wait_ms(10);
        check_rst(1'b1);
        $display("brownout test done");
    endtask

    task automatic t_manual;
        @(posedge clk) manual_request_n <= 1'b0;
        repeat (25) @(posedge clk);
        set_mr(1'b1, 30);
        check_rst(1'b1);
        for (int i = 0; i < 5; i++)
            set_mr(i[0], 1);
        set_mr(1'b0, 50);
        check_rst(1'b0);
        for (int i = 0; i < 5; i++)
            set_mr(!i[0], 1);
        wait_ms(190);
        check_rst(1'b0);
        wait_ms(40);
        check_rst(1'b1);
        $display("manual request test done");
    endtask

    task automatic t_watchdog;
        wait_ms(1700);
        check_rst(1'b1);
        @(posedge clk) kick_en <= 1'b0;
        @(posedge clk) kick_en <= 1'b1;
        repeat (4) @(posedge clk);
        kick_en <= 1'b0;
        wait_ms(1580);
        check_rst(1'b1);
        wait_ms(40);
        check_rst(1'b0);
        wait_ms(200);
        check_rst(1'b1);
        $display("watchdog test done");
    endtask

    task automatic t_floating;
        @(posedge clk) float_en <= 1'b1;
        wait_ms(1000);
        check("kick_drive_oe", kick_drive_oe, 1'b1);
        check("kick_drive", kick_drive, 1'b0);
        wait_ms(800);
        check("drive_seen", drive_seen, 1'b1);
        check_rst(1'b1);
        $display("floating kick test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_brownout();
        t_manual();
        t_watchdog();
        t_floating();
        results();
    end
endmodule
